// ---- src/vh_voltage_hold.sv ----
// voltage hold controller with avalon-mm registers and event interrupt
//
// Design decisions made here: the Avalon-MM register port and the address map.
module vh_voltage_hold
  import vh_pkg::*;
#(
  parameter int TICK_CYCLES = STEP_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic cycle_start,
  input wire logic block_in,
  input wire logic [VW-1:0] volt_mag_a,
  input wire logic [VW-1:0] volt_mag_b,
  input wire logic [VW-1:0] volt_mag_c,
  input wire logic [VW-1:0] volt_ang_a,
  input wire logic [VW-1:0] volt_ang_b,
  input wire logic [VW-1:0] volt_ang_c,
  input wire logic [VW-1:0] cur_mag_a,
  input wire logic [VW-1:0] cur_mag_b,
  input wire logic [VW-1:0] cur_mag_c,
  input wire logic [VW-1:0] third_phase_current_freq,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic hold_active,
  output logic nondir_fallback,
  output logic current_freq_follow,
  output logic [VW-1:0] sample_freq,
  output logic [VW-1:0] hold_amp_a,
  output logic [VW-1:0] hold_amp_b,
  output logic [VW-1:0] hold_amp_c,
  output logic [VW-1:0] hold_ang_a,
  output logic [VW-1:0] hold_ang_b,
  output logic [VW-1:0] hold_ang_c,
  output logic irq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic blk_s1;
    logic blk_s2;
    logic enable;
    logic cur_en;
    logic ffol_en;
    logic [NPH-1:0] used;
    logic [VW-1:0] thr;
    logic [VW-1:0] pick;
    logic [VW-1:0] maxdur;
    logic [VW-1:0] nomf;
    vh_state_t st;
    logic [31:0] presc;
    logic [VW-1:0] dur;
    logic blk;
    logic vlow;
    logic ihigh;
    logic ffol;
    logic [EVW-1:0] evt;
    logic [EVW-1:0] evt_en;
    logic [NPH-1:0][VW-1:0] vout;
    logic [NPH-1:0][VW-1:0] aout;
    logic [VW-1:0] sfreq;
    logic ack;
    logic [31:0] rdata;
  } vh_regs_t;

  localparam vh_regs_t RST = '{thr: THR_RST, maxdur: DUR_RST, nomf: NOMF_RST,
                               used: USED_RST, st: ST_IDLE, default: '0};

  vh_regs_t s_reg;
  vh_regs_t s_next;

  logic [NPH-1:0][VW-1:0] vin;
  logic [NPH-1:0][VW-1:0] ain;
  logic [NPH-1:0][VW-1:0] iin;
  logic vlow_c;
  logic ihigh_c;
  logic engage_c;
  logic [EVW-1:0] evt_set;
  logic [EVW-1:0] evt_clr;

  assign vin = {volt_mag_c, volt_mag_b, volt_mag_a};
  assign ain = {volt_ang_c, volt_ang_b, volt_ang_a};
  assign iin = {cur_mag_c, cur_mag_b, cur_mag_a};

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [VW-1:0] clamp(input logic [VW-1:0] v,
                                          input logic [VW-1:0] lo,
                                          input logic [VW-1:0] hi);
    logic [VW-1:0] r;
    r = v;
    if (v < lo) begin
      r = lo;
    end else if (v > hi) begin
      r = hi;
    end
    return r;
  endfunction

  function automatic logic [1:0] edges(input logic now, input logic was);
    return {~now & was, now & ~was};
  endfunction

  function automatic logic [31:0] rd_word(input vh_regs_t s, input logic [3:0] a);
    logic [31:0] w;
    w = '0;
    case (a)
      ADDR_CTRL: begin
        w[CTRL_ENABLE_BIT] = s.enable;
        w[CTRL_CUR_EN_BIT] = s.cur_en;
        w[CTRL_FFOL_BIT] = s.ffol_en;
        w[CTRL_USED_LSB +: NPH] = s.used;
      end
      ADDR_THRESH: w[VW-1:0] = s.thr;
      ADDR_PICKUP: w[VW-1:0] = s.pick;
      ADDR_MAXDUR: w[VW-1:0] = s.maxdur;
      ADDR_NOMFREQ: w[VW-1:0] = s.nomf;
      ADDR_STATUS: begin
        w[STAT_HOLD_BIT] = s.st == ST_HOLD;
        w[STAT_VLOW_BIT] = s.vlow;
        w[STAT_IHIGH_BIT] = s.ihigh;
        w[STAT_FFOL_BIT] = s.ffol;
        w[STAT_BLK_BIT] = s.blk;
        w[STAT_EXP_BIT] = s.st == ST_EXPIRED;
      end
      ADDR_EVT_STAT: w[EVW-1:0] = s.evt;
      ADDR_EVT_EN: w[EVW-1:0] = s.evt_en;
      default: w = '0;
    endcase
    return w;
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.blk_s1 = block_in;
    s_next.blk_s2 = s_reg.blk_s1;

    vlow_c = |s_reg.used;
    ihigh_c = 1'b0;
    for (int i = 0; i < NPH; i++) begin
      if (s_reg.used[i] && vin[i] >= s_reg.thr) begin
        vlow_c = 1'b0;
      end
      if (iin[i] > s_reg.pick) begin
        ihigh_c = 1'b1;
      end
    end
    engage_c = s_reg.enable & vlow_c & (~s_reg.cur_en | ihigh_c) & ~s_reg.blk_s2;

    // bus slave: one wait cycle, then answer
    evt_clr = '0;
    s_next.ack = (avs_read | avs_write) & ~s_reg.ack;
    if (avs_read && !s_reg.ack) begin
      s_next.rdata = rd_word(s_reg, avs_address);
    end
    if (avs_write && !s_reg.ack) begin
      case (avs_address)
        ADDR_CTRL: begin
          s_next.enable = avs_writedata[CTRL_ENABLE_BIT];
          s_next.cur_en = avs_writedata[CTRL_CUR_EN_BIT];
          s_next.ffol_en = avs_writedata[CTRL_FFOL_BIT];
          s_next.used = avs_writedata[CTRL_USED_LSB +: NPH];
        end
        ADDR_THRESH: s_next.thr = clamp(avs_writedata[VW-1:0], THR_MIN, THR_MAX);
        ADDR_PICKUP: s_next.pick = avs_writedata[VW-1:0];
        ADDR_MAXDUR: s_next.maxdur = clamp(avs_writedata[VW-1:0], DUR_MIN, DUR_MAX);
        ADDR_NOMFREQ: s_next.nomf = avs_writedata[VW-1:0];
        ADDR_EVT_CLR: evt_clr = avs_writedata[EVW-1:0];
        ADDR_EVT_EN: s_next.evt_en = avs_writedata[EVW-1:0];
        default: s_next.evt_en = s_reg.evt_en;
      endcase
    end

    // program cycle sampling
    if (cycle_start) begin
      s_next.blk = s_reg.blk_s2;
      s_next.vlow = vlow_c;
      s_next.ihigh = ihigh_c;
      s_next.ffol = s_reg.ffol_en & s_reg.enable & vlow_c;
    end

    // definite-time duration counter
    if (s_reg.st == ST_HOLD) begin
      if (s_reg.presc == 32'(TICK_CYCLES - 1)) begin
        s_next.presc = '0;
        s_next.dur = s_reg.dur + 16'h0001;
      end else begin
        s_next.presc = s_reg.presc + 32'h1;
      end
    end else begin
      s_next.presc = '0;
      s_next.dur = '0;
    end

    case (s_reg.st)
      ST_IDLE: begin
        if (cycle_start && engage_c) begin
          s_next.st = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (s_reg.dur >= s_reg.maxdur) begin
          s_next.st = ST_EXPIRED;
        end else if (cycle_start && (s_reg.blk_s2 || !vlow_c)) begin
          s_next.st = ST_IDLE;
        end
      end
      ST_EXPIRED: begin
        if (cycle_start && !vlow_c) begin
          s_next.st = ST_IDLE;
        end
      end
      default: s_next.st = ST_IDLE;
    endcase
    if (!s_reg.enable) begin
      s_next.st = ST_IDLE;
    end

    // substituted amplitude and frozen angle
    for (int i = 0; i < NPH; i++) begin
      if (s_next.st == ST_HOLD) begin
        s_next.vout[i] = s_reg.thr;
        s_next.aout[i] = s_reg.aout[i];
      end else begin
        s_next.vout[i] = vin[i];
        s_next.aout[i] = ain[i];
      end
    end
    s_next.sfreq = s_next.ffol ? third_phase_current_freq : s_reg.nomf;

    // events, set wins over clear
    evt_set[EV_DISABLED:EV_ENABLED] = edges(s_next.enable, s_reg.enable);
    evt_set[EV_VLOW_OFF:EV_VLOW_ON] = edges(s_next.vlow, s_reg.vlow);
    evt_set[EV_IHI_OFF:EV_IHI_ON] = edges(s_next.ihigh, s_reg.ihigh);
    evt_set[EV_FFOL_OFF:EV_FFOL_ON] = edges(s_next.ffol, s_reg.ffol);
    evt_set[EV_USE_OFF:EV_USE_ON] = edges(s_next.st == ST_HOLD, s_reg.st == ST_HOLD);
    evt_set[EV_BLK_OFF:EV_BLK_ON] = edges(s_next.blk, s_reg.blk);
    s_next.evt = (s_reg.evt & ~evt_clr) | evt_set;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_reg <= RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign avs_waitrequest = (avs_read | avs_write) & ~s_reg.ack;
  assign avs_readdata = s_reg.rdata;
  assign hold_active = s_reg.st == ST_HOLD;
  assign nondir_fallback = s_reg.st == ST_EXPIRED;
  assign current_freq_follow = s_reg.ffol;
  assign sample_freq = s_reg.sfreq;
  assign hold_amp_a = s_reg.vout[0];
  assign hold_amp_b = s_reg.vout[1];
  assign hold_amp_c = s_reg.vout[2];
  assign hold_ang_a = s_reg.aout[0];
  assign hold_ang_b = s_reg.aout[1];
  assign hold_ang_c = s_reg.aout[2];
  assign irq = |(s_reg.evt & s_reg.evt_en);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  AST_ENGAGE_VLOW: assert property ($rose(hold_active) |-> s_reg.vlow)
    else $error("hold engaged without low voltage");
  AST_ENGAGE_CURRENT: assert property ($rose(hold_active) |-> (!s_reg.cur_en || s_reg.ihigh))
    else $error("hold engaged without current condition");
  AST_AMP_THRESH: assert property ((hold_active && $stable(s_reg.thr)) |-> hold_amp_a == s_reg.thr)
    else $error("hold amplitude differs from threshold");
  AST_ANGLE_FROZEN: assert property ((hold_active && $past(hold_active)) |-> $stable(hold_ang_b))
    else $error("angle moved while holding");
  AST_CYCLE_START: assert property ($rose(hold_active) |-> $past(cycle_start))
    else $error("hold engaged outside program cycle start");
  AST_THR_RANGE: assert property (s_reg.thr >= THR_MIN && s_reg.thr <= THR_MAX)
    else $error("threshold out of range");
  AST_DUR_LIMIT: assert property (hold_active |-> s_reg.dur <= s_reg.maxdur)
    else $error("hold exceeded maximum duration");
  AST_EXPIRE: assert property ((hold_active && s_reg.dur >= s_reg.maxdur
                                && s_reg.enable) |=> nondir_fallback && !hold_active)
    else $error("expiry did not force fallback");
  AST_BLOCK_ENDS: assert property ((hold_active && cycle_start && s_reg.blk_s2
                                    && s_reg.dur < s_reg.maxdur) |=> !hold_active)
    else $error("block input did not end hold");
  AST_FREQ_FOLLOW: assert property (current_freq_follow |-> sample_freq
                                    == $past(third_phase_current_freq))
    else $error("sampling frequency not from third phase current");
  AST_VLOW_EVT: assert property ($rose(s_reg.vlow) |-> s_reg.evt[EV_VLOW_ON])
    else $error("low voltage on event missing");
  AST_USE_EVT: assert property ($fell(hold_active) |-> s_reg.evt[EV_USE_OFF])
    else $error("hold off event missing");
  AST_ANGLE_TRACK: assert property (($past(reset_n) && !hold_active)
                                    |-> hold_ang_a == $past(volt_ang_a))
    else $error("angle latch not tracking");

  // ----------------------------------------------------------------
  // checks: engagement and release
  // ----------------------------------------------------------------
  AST_VLOW_NEEDED: assert property ((!hold_active && !vlow_c) |=> !hold_active)
    else $error("hold engaged with a used voltage above threshold");
  AST_CUR_NEEDED: assert property ((!hold_active && s_reg.cur_en && !ihigh_c)
                                   |=> !hold_active)
    else $error("hold engaged on low voltage alone");
  AST_BLOCK_NO_ENGAGE: assert property ((!hold_active && s_reg.blk_s2) |=> !hold_active)
    else $error("hold engaged while blocked");
  AST_RECOVER_ENDS: assert property ((hold_active && cycle_start && !vlow_c)
                                     |=> !hold_active)
    else $error("voltage recovery did not end hold");
  AST_EXPIRED_STAYS_OFF: assert property (nondir_fallback |=> !hold_active)
    else $error("hold engaged straight from expiry");
  AST_DISABLED_IDLE: assert property (!s_reg.enable |=> !hold_active && !nondir_fallback)
    else $error("hold or expiry kept while disabled");

  // ----------------------------------------------------------------
  // checks: substituted outputs
  // ----------------------------------------------------------------
  AST_AMP_B: assert property (hold_active |-> hold_amp_b == $past(s_reg.thr))
    else $error("phase b amplitude differs from threshold");
  AST_AMP_C: assert property (hold_active |-> hold_amp_c == $past(s_reg.thr))
    else $error("phase c amplitude differs from threshold");
  AST_ANGLE_FROZEN_A: assert property ((hold_active && $past(hold_active))
                                       |-> $stable(hold_ang_a))
    else $error("phase a angle moved while holding");
  AST_ANGLE_FROZEN_C: assert property ((hold_active && $past(hold_active))
                                       |-> $stable(hold_ang_c))
    else $error("phase c angle moved while holding");
  AST_ANGLE_LATCH: assert property ($rose(hold_active) |-> $stable(hold_ang_a))
    else $error("angle latch did not freeze on engagement");
  AST_FREQ_NOMINAL: assert property (($past(reset_n) && !current_freq_follow)
                                     |-> sample_freq == $past(s_reg.nomf))
    else $error("sampling frequency not nominal");

  // ----------------------------------------------------------------
  // checks: events
  // ----------------------------------------------------------------
  AST_EN_EVT: assert property ($rose(s_reg.enable) |-> s_reg.evt[EV_ENABLED])
    else $error("enabled event missing");
  AST_DIS_EVT: assert property ($fell(s_reg.enable) |-> s_reg.evt[EV_DISABLED])
    else $error("disabled event missing");
  AST_IHI_EVT: assert property ($fell(s_reg.ihigh) |-> s_reg.evt[EV_IHI_OFF])
    else $error("high current off event missing");
  AST_FFOL_EVT: assert property ($rose(current_freq_follow) |-> s_reg.evt[EV_FFOL_ON])
    else $error("frequency follow on event missing");
  AST_BLK_EVT: assert property ($rose(s_reg.blk) |-> s_reg.evt[EV_BLK_ON])
    else $error("block on event missing");

endmodule

// ---- src/vh_pkg.sv ----
// constants, types and register map of the voltage hold controller
package vh_pkg;

  // ----------------------------------------------------------------
  // register word indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL     = 4'h0;
  localparam logic [3:0] ADDR_THRESH   = 4'h1;
  localparam logic [3:0] ADDR_PICKUP   = 4'h2;
  localparam logic [3:0] ADDR_MAXDUR   = 4'h3;
  localparam logic [3:0] ADDR_NOMFREQ  = 4'h4;
  localparam logic [3:0] ADDR_STATUS   = 4'h5;
  localparam logic [3:0] ADDR_EVT_STAT = 4'h6;
  localparam logic [3:0] ADDR_EVT_CLR  = 4'h7;
  localparam logic [3:0] ADDR_EVT_EN   = 4'h8;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_CUR_EN_BIT = 1;
  localparam int CTRL_FFOL_BIT   = 2;
  localparam int CTRL_USED_LSB   = 3;
  localparam int NPH             = 3;
  localparam int VW              = 16;
  localparam int EVW             = 12;

  localparam int EV_ENABLED  = 0;
  localparam int EV_DISABLED = 1;
  localparam int EV_VLOW_ON  = 2;
  localparam int EV_VLOW_OFF = 3;
  localparam int EV_IHI_ON   = 4;
  localparam int EV_IHI_OFF  = 5;
  localparam int EV_FFOL_ON  = 6;
  localparam int EV_FFOL_OFF = 7;
  localparam int EV_USE_ON   = 8;
  localparam int EV_USE_OFF  = 9;
  localparam int EV_BLK_ON   = 10;
  localparam int EV_BLK_OFF  = 11;

  localparam int STAT_HOLD_BIT  = 0;
  localparam int STAT_VLOW_BIT  = 1;
  localparam int STAT_IHIGH_BIT = 2;
  localparam int STAT_FFOL_BIT  = 3;
  localparam int STAT_BLK_BIT   = 4;
  localparam int STAT_EXP_BIT   = 5;

  // ----------------------------------------------------------------
  // limits (volts in 0.01 V, durations in 10 ms steps) and resets
  // ----------------------------------------------------------------
  localparam logic [15:0] THR_MIN   = 16'h00C8;
  localparam logic [15:0] THR_MAX   = 16'h1388;
  localparam logic [15:0] THR_RST   = 16'h00C8;
  localparam logic [15:0] DUR_MIN   = 16'h0002;
  localparam logic [15:0] DUR_MAX   = 16'h1388;
  localparam logic [15:0] DUR_RST   = 16'h0032;
  localparam logic [15:0] NOMF_RST  = 16'h1388;
  localparam logic [2:0]  USED_RST  = 3'h7;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int STEP_TIME_US  = 10000;
  localparam int STEP_CYCLES   = STEP_TIME_US * 1000 / CLK_PERIOD_NS;

  typedef enum logic [1:0] {ST_IDLE, ST_HOLD, ST_EXPIRED} vh_state_t;

endpackage

// ---- verification/vh_stage_model.sv ----
// protection stage model: program cycle pulses and direction mode
module vh_stage_model
  import vh_pkg::*;
#(
  parameter int CYC = 20
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic nondir_fallback,
  output logic cycle_start,
  output logic stage_dir
);
  logic [7:0] cnt_reg;
  // ----------------------------------------------------------------
  // program cycle start, one clock wide
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_reg <= 8'h00;
      cycle_start <= 1'b0;
    end else begin
      cnt_reg <= (cnt_reg == 8'(CYC - 1)) ? 8'h00 : cnt_reg + 8'h01;
      cycle_start <= (cnt_reg == 8'(CYC - 1));
    end
  end
  // stages leave directional mode on expiry
  assign stage_dir = !nondir_fallback;
endmodule

// ---- verification/test_vh_voltage_hold.sv ----
// self-checking bench of the voltage hold controller
module test_vh_voltage_hold
  import vh_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, reset_n, block_in, avs_read, avs_write, avs_waitrequest, irq;
  logic hold_active, nondir_fallback, current_freq_follow, cycle_start, stage_dir;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [VW-1:0] vm [3];
  logic [VW-1:0] va [3];
  logic [VW-1:0] cm [3];
  logic [VW-1:0] amp [3];
  logic [VW-1:0] ang [3];
  logic [VW-1:0] tfreq, sfreq;
  logic [31:0] rst_exp [5] = '{32'h38, 32'hC8, 32'h0, 32'h32, 32'h1388};
  int n_mismatch, total_checks, k;
  // ----------------------------------------------------------------
  // design and stage model
  // ----------------------------------------------------------------
  vh_voltage_hold #(.TICK_CYCLES(4)) dut (.clk(clk), .reset_n(reset_n),
    .cycle_start(cycle_start), .block_in(block_in),
    .volt_mag_a(vm[0]), .volt_mag_b(vm[1]), .volt_mag_c(vm[2]),
    .volt_ang_a(va[0]), .volt_ang_b(va[1]), .volt_ang_c(va[2]),
    .cur_mag_a(cm[0]), .cur_mag_b(cm[1]), .cur_mag_c(cm[2]),
    .third_phase_current_freq(tfreq), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .hold_active(hold_active),
    .nondir_fallback(nondir_fallback), .current_freq_follow(current_freq_follow),
    .sample_freq(sfreq), .hold_amp_a(amp[0]), .hold_amp_b(amp[1]), .hold_amp_c(amp[2]),
    .hold_ang_a(ang[0]), .hold_ang_b(ang[1]), .hold_ang_c(ang[2]), .irq(irq));
  vh_stage_model #(.CYC(20)) stages (.clk(clk), .reset_n(reset_n),
    .nondir_fallback(nondir_fallback), .cycle_start(cycle_start), .stage_dir(stage_dir));
  always #5 clk = ~clk;
  // ----------------------------------------------------------------
  // compare, bus and wait tasks
  // ----------------------------------------------------------------
  task automatic give_verdict;
    if (n_mismatch == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_sig(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0) break;
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (i == 50) begin
      n_mismatch++;
      give_verdict;
    end
  endtask
  task automatic rdm(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk_reg(rd & m, e);
  endtask
  task automatic wait_cs(input int n);
    int i;
    for (int c = 0; c < n; c++) begin
      for (i = 0; i < 100; i++) begin
        @(posedge clk);
        if (cycle_start) break;
      end
      if (i == 100) begin
        n_mismatch++;
        give_verdict;
      end
    end
    repeat (2) @(posedge clk);
  endtask
  task automatic setv(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
    @(posedge clk);
    vm[0] <= a;
    vm[1] <= b;
    vm[2] <= c;
  endtask
  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 0; reset_n = 0; block_in = 0; avs_read = 0; avs_write = 0;
    avs_address = 4'h0; avs_writedata = 32'h0; tfreq = 16'h1324;
    vm = '{16'h07D0, 16'h07D0, 16'h07D0};
    va = '{16'h03E8, 16'h07D0, 16'h0BB8};
    cm = '{16'h0064, 16'h0064, 16'h0064};
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    for (k = 0; k < 5; k++) rdm(4'(k), 32'hFFFFFFFF, rst_exp[k]);
    rdm(ADDR_EVT_EN, 32'hFFFFFFFF, 32'h0);
    rdm(4'h9, 32'hFFFFFFFF, 32'h0);
    bus(1'b1, ADDR_THRESH, 32'h64);
    rdm(ADDR_THRESH, 32'hFFFFFFFF, 32'hC8);
    bus(1'b1, ADDR_THRESH, 32'hFFFF);
    rdm(ADDR_THRESH, 32'hFFFFFFFF, 32'h1388);
    bus(1'b1, ADDR_MAXDUR, 32'h1);
    rdm(ADDR_MAXDUR, 32'hFFFFFFFF, 32'h2);
    bus(1'b1, ADDR_MAXDUR, 32'hFFFF);
    rdm(ADDR_MAXDUR, 32'hFFFFFFFF, 32'h1388);
    bus(1'b1, ADDR_THRESH, 32'h3E8);
    bus(1'b1, ADDR_MAXDUR, 32'h2);
    bus(1'b1, ADDR_EVT_EN, 32'hFFF);
    bus(1'b1, ADDR_CTRL, 32'h39);
    rdm(ADDR_EVT_STAT, 32'h1, 32'h1);
    chk_sig(16'(irq), 16'h1);
    bus(1'b1, ADDR_EVT_EN, 32'h0);
    chk_sig(16'(irq), 16'h0);
    bus(1'b1, ADDR_EVT_EN, 32'hFFF);
    bus(1'b1, ADDR_EVT_CLR, 32'hFFF);
    chk_sig(16'(irq), 16'h0);
    setv(16'h01F4, 16'h01F4, 16'h07D0);
    wait_cs(1);
    chk_sig(16'(hold_active), 16'h0);
    bus(1'b1, ADDR_CTRL, 32'h19);
    wait_cs(1);
    chk_sig(16'(hold_active), 16'h1);
    for (k = 0; k < 3; k++) chk_sig(amp[k], 16'h03E8);
    va <= '{16'h0111, 16'h0222, 16'h0333};
    repeat (2) @(posedge clk);
    for (k = 0; k < 3; k++) chk_sig(ang[k], 16'(1000 * (k + 1)));
    for (k = 0; k < 100 && nondir_fallback !== 1'b1; k++) @(posedge clk);
    if (k == 100) begin
      n_mismatch++;
      give_verdict;
    end
    chk_sig(16'(hold_active), 16'h0);
    chk_sig(16'(stage_dir), 16'h0);
    rdm(ADDR_EVT_STAT, 32'h304, 32'h304);
    rdm(ADDR_STATUS, 32'h23, 32'h22);
    setv(16'h07D0, 16'h07D0, 16'h07D0);
    wait_cs(1);
    chk_sig(16'(nondir_fallback), 16'h0);
    rdm(ADDR_EVT_STAT, 32'h8, 32'h8);
    bus(1'b1, ADDR_MAXDUR, 32'h1388);
    bus(1'b1, ADDR_PICKUP, 32'h1F4);
    bus(1'b1, ADDR_CTRL, 32'h1B);
    setv(16'h01F4, 16'h01F4, 16'h07D0);
    wait_cs(1);
    chk_sig(16'(hold_active), 16'h0);
    cm[2] <= 16'h0258;
    wait_cs(1);
    chk_sig(16'(hold_active), 16'h1);
    rdm(ADDR_EVT_STAT, 32'h10, 32'h10);
    block_in <= 1'b1;
    wait_cs(2);
    chk_sig(16'(hold_active), 16'h0);
    rdm(ADDR_EVT_STAT, 32'h400, 32'h400);
    rdm(ADDR_STATUS, 32'h11, 32'h10);
    block_in <= 1'b0;
    bus(1'b1, ADDR_CTRL, 32'h1D);
    wait_cs(2);
    chk_sig(16'(current_freq_follow), 16'h1);
    chk_sig(sfreq, 16'h1324);
    tfreq <= 16'h1300;
    repeat (2) @(posedge clk);
    chk_sig(sfreq, 16'h1300);
    setv(16'h07D0, 16'h07D0, 16'h07D0);
    wait_cs(1);
    chk_sig(sfreq, NOMF_RST);
    rdm(ADDR_EVT_STAT, 32'hC0, 32'hC0);
    bus(1'b1, ADDR_CTRL, 32'h0);
    rdm(ADDR_EVT_STAT, 32'h2, 32'h2);
    give_verdict;
  end
endmodule
